// ===== src/ctrl_b_pkg.sv
// Purpose: Constants and types for the timer control-B register bank
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   Register indices are kept, byte address is four times the index
package ctrl_b_pkg;
   // Register indices and byte addresses
   localparam logic [7:0]  CLEAR_IDX     = 8'h04;
   localparam logic [7:0]  SET_IDX       = 8'h05;
   localparam logic [7:0]  BUSY_IDX      = 8'h08;
   localparam logic [11:0] CLEAR_ADDR    = {2'h0, CLEAR_IDX, 2'h0};
   localparam logic [11:0] SET_ADDR      = {2'h0, SET_IDX, 2'h0};
   localparam logic [11:0] BUSY_ADDR     = {2'h0, BUSY_IDX, 2'h0};
   // Reset values
   localparam logic [7:0]  CTRL_RESET    = 8'h00;
   localparam logic [31:0] BUSY_RESET    = 32'h0000_0000;
   // Control field positions
   localparam int          DIR_BIT       = 0;
   localparam int          LOCK_BIT      = 1;
   localparam int          SINGLE_BIT    = 2;
   localparam int          RAMP_LSB      = 3;
   localparam int          CMD_LSB       = 5;
   // Busy field positions
   localparam int          BUSY_SOFT_RST = 0;
   localparam int          BUSY_CTRL_B   = 2;
   localparam int          BUSY_CMP_LSB  = 8;
   localparam int          BUSY_PATB     = 16;
   localparam int          BUSY_SHAPEB   = 17;
   localparam int          BUSY_CYCB     = 18;
   localparam int          BUSY_CMPB_LSB = 19;
   // Timer commands
   localparam logic [2:0]  CMD_NONE      = 3'h0;
   localparam logic [2:0]  CMD_RETRIG    = 3'h1;
   localparam logic [2:0]  CMD_STOP      = 3'h2;
   localparam logic [2:0]  CMD_UPDATE    = 3'h3;
   localparam logic [2:0]  CMD_READBACK  = 3'h4;
   // Ramp cycle commands
   localparam logic [1:0]  RAMP_TOGGLE   = 2'h0;
   localparam logic [1:0]  RAMP_SET_B    = 2'h1;
   localparam logic [1:0]  RAMP_SET_A    = 2'h2;
   localparam logic [1:0]  RAMP_HOLD     = 2'h3;
   // Crossing time in pclk cycles
   localparam int          SYNC_CYCLES   = 2;

   typedef struct packed {
      logic [2:0] cmd;
      logic [1:0] ramp_cycle_command;
      logic       single_run_mode;
      logic       buffer_transfer_lock;
      logic       dir;
   } ctrl_b_t;
endpackage : ctrl_b_pkg

// ===== src/ctrl_b_bank.sv
// Purpose: Control-B set/clear register pair and crossing busy register
// Assumes: pclk domain only; timer events arrive as same-clock pulses
// Notes:   Zero-wait decode is traded for flopped outputs: one wait state
//
// Overview of operation
// - Lock set blocks copying buffers to active registers on hardware update.
// - Lock clear lets each hardware update copy all buffers to actives.
// - Lock is ignored while input capture is enabled.
// - Writing one to lock via clear register releases it; zero ignored.
// - Writing one to lock via set register engages it; zero ignored.
// - Direction zero counts up, one counts down.
// - Writing one to direction via clear register makes it count up.
// - Set and clear registers share one state, read back alike.
// - Command codes none, retrigger, stop, update, read sync; zero ignored.
// - Posted command runs on first prescaled tick after the crossing, then reads zero.
// - Ramp command acts only in the two dual-slope modes.
// - On update, pending ramp command runs, index updates, field clears.
// - Ramp codes toggle, force B, force A, hold; zero write ignored.
// - Writing one to single-run via set register enables it.
// - With single-run off the timer counts continuously past wrap.
// - Set and clear register writes cross domains, flagged by busy.
// - Busy bits read-only, set on crossing start, clear on completion.
// - Compare buffer busy at 19..22 all from one bit, compare busy at 8..11 per channel.
// - Busy bits 18,17,16 buffers; bits 7..3 and 1..0 the plain registers, bit 2 control-B.
// - Writing ones to command fields via clear register cancels them.
// - Writing one to single-run via clear register disables it.
//
// The APB register port is this design's own decision.
module ctrl_b_bank #(
   parameter int CHANNELS    = 4,
   parameter int SYNC_CYCLES = ctrl_b_pkg::SYNC_CYCLES
) (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // Timer events
   input  wire logic        presc_tick,
   input  wire logic        hw_update,
   input  wire logic        wrap_event,
   input  wire logic        capture_en,
   input  wire logic        dual_slope_ramp,
   input  wire logic        dual_slope_ramp_alt,
   input  wire logic [7:0]  other_busy,
   input  wire logic [7:0]  buffer_busy,
   // Timer controls
   output logic             count_down,
   output logic             running,
   output logic             copy_buffers,
   output logic             retrigger_pulse,
   output logic             count_readback_sync,
   output logic             ramp_cycle_index
);
   ctrl_b_pkg::ctrl_b_t ctrl_r, ctrl_nxt, wr;
   logic [31:0] busy_r, busy_nxt;
   logic [3:0]  sync_cnt_r;
   logic        pready_r, pslverr_r, run_r, copy_r, retrig_r, rsync_r, idx_r;
   logic [31:0] prdata_r;

   // Decode
   wire         access     = psel & penable;
   wire         commit     = access & pready_r;
   wire         hit_clear  = paddr == ctrl_b_pkg::CLEAR_ADDR;
   wire         hit_set    = paddr == ctrl_b_pkg::SET_ADDR;
   wire         hit_busy   = paddr == ctrl_b_pkg::BUSY_ADDR;
   wire         mapped     = hit_clear | hit_set | hit_busy;
   wire         wr_set     = commit & pwrite & hit_set;
   wire         wr_clear   = commit & pwrite & hit_clear;
   wire         ctrl_busy  = busy_r[ctrl_b_pkg::BUSY_CTRL_B];
   wire         cmd_valid  = wr.cmd != ctrl_b_pkg::CMD_NONE && wr.cmd <= ctrl_b_pkg::CMD_READBACK;
   wire         cmd_fire   = presc_tick & ~ctrl_busy & (ctrl_r.cmd != ctrl_b_pkg::CMD_NONE);
   wire         retrig_go  = cmd_fire & (ctrl_r.cmd == ctrl_b_pkg::CMD_RETRIG);
   wire         rsync_go   = cmd_fire & (ctrl_r.cmd == ctrl_b_pkg::CMD_READBACK);
   wire         dual_mode  = dual_slope_ramp | dual_slope_ramp_alt;
   wire         lock_on    = ctrl_r.buffer_transfer_lock & ~capture_en;
   wire         force_upd  = cmd_fire & (ctrl_r.cmd == ctrl_b_pkg::CMD_UPDATE);
   wire         do_copy    = (hw_update & ~lock_on) | force_upd;
   wire         stop_now   = (cmd_fire & (ctrl_r.cmd == ctrl_b_pkg::CMD_STOP))
                           | (wrap_event & ctrl_r.single_run_mode);
   wire [3:0]   chan_mask  = 4'((1 << CHANNELS) - 1);

   assign wr = pwdata[7:0];

   // Shared control state; hardware clears lose to a fresh post
   always_comb begin
      ctrl_nxt = ctrl_r;
      if (cmd_fire)
         ctrl_nxt.cmd = ctrl_b_pkg::CMD_NONE;
      if (hw_update & dual_mode)
         ctrl_nxt.ramp_cycle_command = ctrl_b_pkg::RAMP_TOGGLE;
      if (wr_set) begin
         if (wr.dir) ctrl_nxt.dir = 1'b1;
         if (wr.buffer_transfer_lock) ctrl_nxt.buffer_transfer_lock = 1'b1;
         if (wr.single_run_mode) ctrl_nxt.single_run_mode = 1'b1;
         if (cmd_valid) ctrl_nxt.cmd = wr.cmd;
         if (wr.ramp_cycle_command != 2'h0) begin
            ctrl_nxt.ramp_cycle_command = wr.ramp_cycle_command;
         end
      end
      if (wr_clear) begin
         if (wr.dir) ctrl_nxt.dir = 1'b0;
         if (wr.buffer_transfer_lock) ctrl_nxt.buffer_transfer_lock = 1'b0;
         if (wr.single_run_mode) ctrl_nxt.single_run_mode = 1'b0;
         if (wr.cmd != 3'h0) ctrl_nxt.cmd = ctrl_b_pkg::CMD_NONE;
         if (wr.ramp_cycle_command != 2'h0) begin
            ctrl_nxt.ramp_cycle_command = ctrl_b_pkg::RAMP_TOGGLE;
         end
      end
   end

   // Busy: control bit held for the crossing, others mirrored from other_busy and buffer_busy
   always_comb begin
      busy_nxt = ctrl_b_pkg::BUSY_RESET;
      busy_nxt[7:0] = other_busy;
      busy_nxt[ctrl_b_pkg::BUSY_CMP_LSB +: 4] = buffer_busy[3:0] & chan_mask;
      busy_nxt[ctrl_b_pkg::BUSY_PATB +: 3] = buffer_busy[6:4];
      busy_nxt[ctrl_b_pkg::BUSY_CMPB_LSB +: 4] = buffer_busy[7] ? chan_mask : 4'h0;
      busy_nxt[ctrl_b_pkg::BUSY_CTRL_B] = (wr_set | wr_clear) | (sync_cnt_r > 4'h1);
   end

   // Index: ramp command only in dual-slope modes
   wire idx_nxt = (ctrl_r.ramp_cycle_command == ctrl_b_pkg::RAMP_SET_B) ? 1'b1 :
                  (ctrl_r.ramp_cycle_command == ctrl_b_pkg::RAMP_SET_A) ? 1'b0 :
                  (ctrl_r.ramp_cycle_command == ctrl_b_pkg::RAMP_HOLD)  ? idx_r : ~idx_r;

   wire [31:0] rd_word = hit_busy ? busy_r : {24'h0, ctrl_r};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= ctrl_b_pkg::CTRL_RESET;
         busy_r <= ctrl_b_pkg::BUSY_RESET;
      end else begin
         ctrl_r <= ctrl_nxt;
         busy_r <= busy_nxt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_cnt_r <= 4'h0;
      end else if (wr_set | wr_clear) begin
         sync_cnt_r <= 4'(SYNC_CYCLES);
      end else if (sync_cnt_r != 4'h0) begin
         sync_cnt_r <= sync_cnt_r - 4'h1;
      end
   end

   // One wait state; response fields come from flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h0000_0000;
      end else begin
         pready_r  <= access & ~pready_r;
         pslverr_r <= access & ~pready_r & ~mapped;
         prdata_r  <= (access & ~pready_r & ~pwrite & mapped) ? rd_word : 32'h0000_0000;
      end
   end

   // Run state: a stop, by command or single-run wrap, beats a retrigger
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_r <= 1'b0;
      end else if (stop_now) begin
         run_r <= 1'b0;
      end else if (retrig_go) begin
         run_r <= 1'b1;
      end
   end

   // Timer strobes last one cycle each
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         copy_r   <= 1'b0;
         retrig_r <= 1'b0;
         rsync_r  <= 1'b0;
      end else begin
         copy_r   <= do_copy;
         retrig_r <= retrig_go;
         rsync_r  <= rsync_go;
      end
   end

   // Index moves only on an update in a dual-slope mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idx_r <= 1'b0;
      end else if (hw_update & dual_mode) begin
         idx_r <= idx_nxt;
      end
   end

   assign pready              = pready_r;
   assign pslverr             = pslverr_r;
   assign prdata              = prdata_r;
   assign count_down          = ctrl_r.dir;
   assign running             = run_r;
   assign copy_buffers        = copy_r;
   assign retrigger_pulse     = retrig_r;
   assign count_readback_sync = rsync_r;
   assign ramp_cycle_index    = idx_r;

   // Checks
   lock_blocks_a: assert property (@(posedge pclk) disable iff (!presetn)
      hw_update && lock_on && !force_upd |=> !copy_buffers)
      else $error("copy while locked");
   unlock_copies_a: assert property (@(posedge pclk) disable iff (!presetn)
      hw_update && !ctrl_r.buffer_transfer_lock |=> copy_buffers)
      else $error("no copy while unlocked");
   capture_ignores_a: assert property (@(posedge pclk) disable iff (!presetn)
      hw_update && capture_en |=> copy_buffers)
      else $error("lock acted during capture");
   clear_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_clear && pwdata[ctrl_b_pkg::LOCK_BIT] |=> !ctrl_r.buffer_transfer_lock)
      else $error("lock not released");
   set_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_set && pwdata[ctrl_b_pkg::LOCK_BIT] && !wr_clear |=> ctrl_r.buffer_transfer_lock)
      else $error("lock not engaged");
   dir_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_clear && pwdata[ctrl_b_pkg::DIR_BIT] |=> !count_down)
      else $error("direction not cleared");
   cmd_done_a: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_fire && !wr_set |=> ctrl_r.cmd == ctrl_b_pkg::CMD_NONE)
      else $error("command not cleared");
   single_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
      wrap_event && ctrl_r.single_run_mode |=> !running)
      else $error("single run kept counting");
   busy_window_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_set && !wr_clear ##1 1'b1 |-> ctrl_busy [*2])
      else $error("busy not held for crossing");
   restart_a: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_fire && ctrl_r.cmd == ctrl_b_pkg::CMD_RETRIG |=> retrigger_pulse ##1 !retrigger_pulse || $past(cmd_fire))
      else $error("retrigger pulse wrong");

   // Set and clear writes on the single-bit fields
   set_dir_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_set && pwdata[ctrl_b_pkg::DIR_BIT]
      |=> count_down)
      else $error("direction not set");

   set_single_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_set && pwdata[ctrl_b_pkg::SINGLE_BIT]
      |=> ctrl_r.single_run_mode)
      else $error("single run not enabled");

   clear_single_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_clear && pwdata[ctrl_b_pkg::SINGLE_BIT]
      |=> !ctrl_r.single_run_mode)
      else $error("single run not disabled");

   // Command posting, refusal and cancel
   post_cmd_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_set && cmd_valid
      |=> ctrl_r.cmd == $past(pwdata[7:5]))
      else $error("command not posted");

   ignore_cmd_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_set && !cmd_valid && !cmd_fire
      |=> ctrl_r.cmd == $past(ctrl_r.cmd))
      else $error("null or invalid command acted");

   cancel_cmd_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_clear && pwdata[7:5] != 3'h0
      |=> ctrl_r.cmd == ctrl_b_pkg::CMD_NONE)
      else $error("command not cancelled");

   cancel_ramp_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_clear && pwdata[4:3] != 2'h0
      |=> ctrl_r.ramp_cycle_command == ctrl_b_pkg::RAMP_TOGGLE)
      else $error("ramp command not cancelled");

   set_ramp_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_set && pwdata[4:3] != 2'h0
      |=> ctrl_r.ramp_cycle_command == $past(pwdata[4:3]))
      else $error("ramp command not posted");

   // Command execution
   stop_cmd_a: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_fire && ctrl_r.cmd == ctrl_b_pkg::CMD_STOP
      |=> !running)
      else $error("stop command ignored");

   force_copy_a: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_fire && ctrl_r.cmd == ctrl_b_pkg::CMD_UPDATE
      |=> copy_buffers)
      else $error("forced update did not copy");

   count_readback_sync_a: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_fire && ctrl_r.cmd == ctrl_b_pkg::CMD_READBACK
      |=> count_readback_sync)
      else $error("read sync pulse missing");

   run_on_a: assert property (@(posedge pclk) disable iff (!presetn)
      wrap_event && !ctrl_r.single_run_mode && !cmd_fire && running
      |=> running)
      else $error("continuous run stopped at wrap");

   // Ramp index
   ramp_done_a: assert property (@(posedge pclk) disable iff (!presetn)
      hw_update && dual_mode && !wr_set
      |=> ctrl_r.ramp_cycle_command == ctrl_b_pkg::RAMP_TOGGLE)
      else $error("ramp command not consumed");

   idx_still_a: assert property (@(posedge pclk) disable iff (!presetn)
      !(hw_update && dual_mode)
      |=> $stable(ramp_cycle_index))
      else $error("index moved outside dual slope update");

   force_b_a: assert property (@(posedge pclk) disable iff (!presetn)
      hw_update && dual_mode && ctrl_r.ramp_cycle_command == ctrl_b_pkg::RAMP_SET_B
      |=> ramp_cycle_index)
      else $error("cycle B not forced");

   force_a_a: assert property (@(posedge pclk) disable iff (!presetn)
      hw_update && dual_mode && ctrl_r.ramp_cycle_command == ctrl_b_pkg::RAMP_SET_A
      |=> !ramp_cycle_index)
      else $error("cycle A not forced");

   hold_idx_a: assert property (@(posedge pclk) disable iff (!presetn)
      hw_update && dual_mode && ctrl_r.ramp_cycle_command == ctrl_b_pkg::RAMP_HOLD
      |=> $stable(ramp_cycle_index))
      else $error("held index changed");

   toggle_idx_a: assert property (@(posedge pclk) disable iff (!presetn)
      hw_update && dual_mode && ctrl_r.ramp_cycle_command == ctrl_b_pkg::RAMP_TOGGLE
      |=> ramp_cycle_index != $past(ramp_cycle_index))
      else $error("index did not toggle");

   // Busy register
   busy_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl_busy && sync_cnt_r <= 4'h1 && !wr_set && !wr_clear
      |=> !ctrl_busy)
      else $error("busy held past crossing");

   busy_mirror_a: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1
      |=> busy_r[7:3] == $past(other_busy[7:3]) && busy_r[1:0] == $past(other_busy[1:0]))
      else $error("plain busy bits not mirrored");

   // Bus response: one wait state, one-cycle answer
   wait_state_a: assert property (@(posedge pclk) disable iff (!presetn)
      access && !pready_r
      |=> pready)
      else $error("ready not given after one wait");

   ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
      pready
      |=> !pready)
      else $error("ready held too long");

   unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
      access && !pready_r && !mapped
      |=> pslverr)
      else $error("unmapped access not flagged");

   write_data_a: assert property (@(posedge pclk) disable iff (!presetn)
      access && !pready_r && pwrite
      |=> prdata == 32'h0000_0000)
      else $error("read data driven on write");
   cover_set_c:   cover property (@(posedge pclk) disable iff (!presetn) wr_set ##[1:8] cmd_fire);
   cover_clear_c: cover property (@(posedge pclk) disable iff (!presetn) wr_clear && pwdata[7:5] != 3'h0);
   cover_idx_c:   cover property (@(posedge pclk) disable iff (!presetn) hw_update && dual_mode);
   cover_lock_c:  cover property (@(posedge pclk) disable iff (!presetn) hw_update && lock_on);
   cover_wrap_c:  cover property (@(posedge pclk) disable iff (!presetn)
      wrap_event && ctrl_r.single_run_mode);
endmodule : ctrl_b_bank

// ===== tb/testbench.sv
// Purpose: Self-checking bench for the control-B register bank
// Assumes: APB master in the bench; timer events are driven as one-cycle pulses
// Notes:   Crossing time is lengthened so busy can be seen by a plain read
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [11:0] SA = ctrl_b_pkg::SET_ADDR;
   localparam logic [11:0] CA = ctrl_b_pkg::CLEAR_ADDR;
   localparam logic [11:0] BA = ctrl_b_pkg::BUSY_ADDR;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic        presc_tick = 0, hw_update = 0, wrap_event = 0, capture_en = 0;
   logic        dual_slope_ramp = 0, dual_slope_ramp_alt = 0;
   logic [7:0]  other_busy = 8'h00, buffer_busy = 8'h00;
   logic        pready, pslverr, count_down, running, copy_buffers;
   logic        retrigger_pulse, count_readback_sync, ramp_cycle_index, errv;
   logic [31:0] prdata, rdv;
   logic [2:0]  seen;
   int          error_cnt = 0, samples_checked = 0;

   // Long crossing keeps busy visible across a whole read
   ctrl_b_bank #(.CHANNELS(4), .SYNC_CYCLES(8)) DUT (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .presc_tick, .hw_update,
      .wrap_event, .capture_en, .dual_slope_ramp, .dual_slope_ramp_alt, .other_busy,
      .buffer_busy, .count_down, .running, .copy_buffers, .retrigger_pulse,
      .count_readback_sync, .ramp_cycle_index);

   always #5 pclk = ~pclk;

   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : stop_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         error_cnt++;
         stop_test();
      end
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rdv, exp);
   endtask : rd_chk

   // Commands only run once the crossing is over, so wait for busy to drop
   task automatic settle;
      int n;
      n = 0;
      do begin
         apb(1'b0, BA, 32'h0);
         n++;
      end while (rdv[2] !== 1'b0 && n < 20);
      if (rdv[2] !== 1'b0) begin
         error_cnt++;
         stop_test();
      end
   endtask : settle

   // One-cycle event: 0 tick, 1 hardware update, 2 wrap; pulses collected after
   task automatic ev(input int k);
      @(posedge pclk);
      case (k)
         0: presc_tick <= 1'b1;
         1: hw_update <= 1'b1;
         default: wrap_event <= 1'b1;
      endcase
      @(posedge pclk);
      presc_tick <= 1'b0; hw_update <= 1'b0; wrap_event <= 1'b0;
      seen = 3'h0;
      repeat (4) begin
         @(posedge pclk);
         seen = seen | {copy_buffers, retrigger_pulse, count_readback_sync};
      end
   endtask : ev

   task automatic t_reset;
      rd_chk(SA, 32'h0);
      rd_chk(CA, 32'h0);
      apb(1'b1, BA, 32'hffff_ffff);
      rd_chk(BA, 32'h0);
   endtask : t_reset

   task automatic t_lock;
      apb(1'b1, SA, 32'h02);
      chk(rdv, 32'h0);
      apb(1'b0, BA, 32'h0);
      chk(rdv[2], 1'b1);
      settle();
      rd_chk(CA, 32'h02);
      ev(1); chk(seen[2], 1'b0);
      capture_en <= 1'b1;
      ev(1); chk(seen[2], 1'b1);
      capture_en <= 1'b0;
      apb(1'b1, CA, 32'h0); settle(); rd_chk(SA, 32'h02);
      apb(1'b1, CA, 32'h02); settle(); rd_chk(SA, 32'h0);
      ev(1); chk(seen[2], 1'b1);
   endtask : t_lock

   task automatic t_dir_single;
      apb(1'b1, SA, 32'h05); settle();
      chk(count_down, 1'b1);
      apb(1'b1, SA, 32'h0); settle(); rd_chk(CA, 32'h05);
      apb(1'b1, CA, 32'h01); settle();
      chk(count_down, 1'b0);
      rd_chk(SA, 32'h04);
      apb(1'b1, SA, 32'h20); settle(); rd_chk(SA, 32'h24);
      ev(0); chk(seen[1], 1'b1);
      chk(running, 1'b1);
      rd_chk(SA, 32'h04);
      ev(2); chk(running, 1'b0);
      apb(1'b1, CA, 32'h04); settle(); rd_chk(SA, 32'h0);
      apb(1'b1, SA, 32'h20); settle(); ev(0);
      ev(2); chk(running, 1'b1);
      apb(1'b1, SA, 32'h40); settle(); ev(0);
      chk(running, 1'b0);
   endtask : t_dir_single

   task automatic t_cmds;
      logic [7:0] code [3] = '{8'h20, 8'h60, 8'h80};
      int         idx  [3] = '{1, 2, 0};
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, SA, {24'h0, code[i]}); settle(); ev(0);
         chk(seen[idx[i]], 1'b1);
      end
      // A cancelled command must not fire on the next tick
      apb(1'b1, SA, 32'ha0); settle(); rd_chk(SA, 32'h0);
      apb(1'b1, SA, 32'h28); apb(1'b1, CA, 32'hf8); settle();
      rd_chk(SA, 32'h0);
      ev(0); chk(seen[1], 1'b0);
   endtask : t_cmds

   task automatic t_ramp;
      logic [7:0] code [4] = '{8'h08, 8'h10, 8'h18, 8'h00};
      logic       exp  [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
      for (int i = 0; i < 4; i++) begin
         dual_slope_ramp <= (i != 3);
         dual_slope_ramp_alt <= (i == 3);
         apb(1'b1, SA, {24'h0, code[i]}); settle(); ev(1);
         chk(ramp_cycle_index, exp[i]);
      end
      rd_chk(SA, 32'h0);
      dual_slope_ramp_alt <= 1'b0;
      apb(1'b1, SA, 32'h10); settle(); ev(1);
      chk(ramp_cycle_index, 1'b1);
   endtask : t_ramp

   task automatic t_busy;
      other_busy <= 8'hff;
      buffer_busy <= 8'hff;
      rd_chk(BA, 32'h007f_0ffb);
      other_busy <= 8'h00;
      buffer_busy <= 8'h40;
      rd_chk(BA, 32'h0004_0000);
      buffer_busy <= 8'h00;
      apb(1'b1, 12'h0c0, 32'hff);
      chk(errv, 1'b1);
      rd_chk(SA, 32'h10);
      chk(errv, 1'b0);
   endtask : t_busy

   // Reset in mid-run drops every control bit and any crossing in flight
   task automatic t_midreset;
      apb(1'b1, SA, 32'h27); settle(); ev(0);
      chk(running, 1'b1);
      apb(1'b1, SA, 32'h03);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      chk(count_down, 1'b0);
      chk(running, 1'b0);
      rd_chk(SA, 32'h0);
      rd_chk(BA, 32'h0);
   endtask : t_midreset

   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_lock();
      t_dir_single();
      t_cmds();
      t_ramp();
      t_busy();
      t_midreset();
      stop_test();
   end
endmodule : testbench
